/* File: rtl/f3s_top.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module f3s_top
    import f3s_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire f3s_req_t bus_req,
    input wire f3s_evt_t events,
    output logic [DATA_W-1:0] rd_data,
    output logic [DATA_W-1:0] third_fault_flags,
    output logic [OVF_DETAIL_W-1:0] overflow_details,
    output logic irq
);

    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        addr_hit = (a == off);
    endfunction

    logic wr_fault;
    logic rd_fault;
    logic rd_detail;
    logic rd_irq_st;
    logic rd_irq_mask;
    logic wr_irq_mask;

    assign wr_fault = bus_req.wr && addr_hit(bus_req.addr, OFF_FAULT3);
    assign rd_fault = bus_req.rd && addr_hit(bus_req.addr, OFF_FAULT3);
    assign rd_detail = bus_req.rd && addr_hit(bus_req.addr, OFF_OVF_DETAIL);
    assign rd_irq_st = bus_req.rd && addr_hit(bus_req.addr, OFF_IRQ_STATUS);
    assign rd_irq_mask = bus_req.rd && addr_hit(bus_req.addr, OFF_IRQ_MASK);
    assign wr_irq_mask = bus_req.wr && addr_hit(bus_req.addr, OFF_IRQ_MASK);

    logic acc_ovf_evt;
    logic sample_counter_overflow_evt;
    logic ovf_evt;
    logic [CB_CELLS-1:0] cb_expiry_evt;

    assign acc_ovf_evt = events.positive_sum_overflow
        || events.negative_sum_overflow
        || events.accumulator_total_overflow;
    assign sample_counter_overflow_evt = events.sample_counter_overflow;
    assign ovf_evt = acc_ovf_evt || sample_counter_overflow_evt;
    // expiry counts only once the driver is off
    assign cb_expiry_evt = events.cb_timer_done & events.cb_driver_off;

    logic [DATA_W-1:0] flag_set;
    logic [DATA_W-1:0] flag_clr;
    logic [DATA_W-1:0] flags;

    always_comb begin
        flag_set = FLAGS_RST;
        flag_set[OVF_BIT] = ovf_evt;
        flag_set[DIAG_BIT] = events.diag_timeout;
        flag_set[CB_LSB +: CB_CELLS] = cb_expiry_evt;
    end

    // a written 0 clears, a written 1 is ignored
    assign flag_clr = wr_fault ? ~bus_req.wdata : FLAGS_RST;

    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_flag
            f3s_flag_cell #(
                .RST_VAL(FLAGS_RST[gi])
            ) u_cell (
                .core_clk(core_clk),
                .rstn(rstn),
                .set_in(flag_set[gi]),
                .clr_in(flag_clr[gi]),
                .q(flags[gi])
            );
        end
    endgenerate

    logic [OVF_DETAIL_W-1:0] det_set;
    logic det_clr;
    logic [OVF_DETAIL_W-1:0] details;

    always_comb begin
        det_set = DETAIL_RST;
        det_set[DET_POS_BIT] = events.positive_sum_overflow;
        det_set[DET_NEG_BIT] = events.negative_sum_overflow;
        det_set[DET_SAMP_BIT] = events.sample_counter_overflow;
        det_set[DET_TOT_BIT] = events.accumulator_total_overflow;
    end

    // clearing the overflow flag takes the details along
    assign det_clr = wr_fault && !bus_req.wdata[OVF_BIT];

    generate
        for (gi = 0; gi < OVF_DETAIL_W; gi++) begin : g_det
            f3s_flag_cell #(
                .RST_VAL(DETAIL_RST[gi])
            ) u_cell (
                .core_clk(core_clk),
                .rstn(rstn),
                .set_in(det_set[gi]),
                .clr_in(det_clr),
                .q(details[gi])
            );
        end
    endgenerate

    assign third_fault_flags = flags;
    assign overflow_details = details;

    // interrupt status, mask and output
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_st_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_mask_nxt;
    logic [IRQ_W-1:0] irq_evt;
    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_evt = IRQ_STATUS_RST;
        irq_evt[IRQ_OVF_BIT] = ovf_evt;
        irq_evt[IRQ_DIAG_BIT] = events.diag_timeout;
        irq_evt[IRQ_CB_BIT] = |cb_expiry_evt;
        irq_st_nxt = irq_st_r;
        if (rd_irq_st) begin
            irq_st_nxt = IRQ_STATUS_RST;
        end
        // events beat the read clear
        irq_st_nxt = irq_st_nxt | irq_evt;
        irq_mask_nxt = irq_mask_r;
        if (wr_irq_mask) begin
            irq_mask_nxt = bus_req.wdata[IRQ_W-1:0];
        end
        // output lags the status by one cycle to stay a pure flop
        irq_nxt = |(irq_st_r & irq_mask_r);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_st_r <= IRQ_STATUS_RST;
            irq_mask_r <= IRQ_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq = irq_r;

    // read path, data valid only in the cycle after the strobe
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = RDATA_RST;
        if (rd_fault) begin
            rdata_nxt = flags;
        end else if (rd_detail) begin
            rdata_nxt[OVF_DETAIL_W-1:0] = details;
        end else if (rd_irq_st) begin
            rdata_nxt[IRQ_W-1:0] = irq_st_r;
        end else if (rd_irq_mask) begin
            rdata_nxt[IRQ_W-1:0] = irq_mask_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rd_data = rdata_r;

    // checks
    default clocking cb_main @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic any_set;
    logic any_det_set;
    assign any_set = |flag_set;
    assign any_det_set = |det_set;

    a_acc_ovf_set: assert property (acc_ovf_evt |=> flags[OVF_BIT])
        else $error("accumulator overflow did not set bit 15");

    a_sample_counter_overflow_set: assert property (sample_counter_overflow_evt |=> flags[OVF_BIT])
        else $error("sample counter overflow did not set bit 15");

    a_ovf_cause: assert property ($rose(flags[OVF_BIT]) |-> $past(ovf_evt))
        else $error("bit 15 rose without an overflow source");

    a_detail_clear: assert property (
        wr_fault && !bus_req.wdata[OVF_BIT] && !any_det_set |=> details == DETAIL_RST)
        else $error("detail indicators survived clearing of bit 15");

    a_detail_keep: assert property (
        !(wr_fault && !bus_req.wdata[OVF_BIT]) |=> (($past(details) & ~details) == 4'h0))
        else $error("detail indicator dropped without bit 15 clear");

    a_write_zero: assert property (
        wr_fault && !any_set |=> flags == ($past(flags) & $past(bus_req.wdata)))
        else $error("write did not clear exactly the zero bits");

    a_flag_sticky: assert property (
        !wr_fault |=> (($past(flags) & ~flags) == 16'h0000))
        else $error("flag dropped without a write");

    a_set_wins: assert property (
        wr_fault && any_set |=> ((flags & $past(flag_set)) == $past(flag_set)))
        else $error("event lost against a clearing write");

    a_diag_set: assert property (events.diag_timeout |=> flags[DIAG_BIT])
        else $error("diagnostic timeout did not set bit 14");

    a_cb_set: assert property (
        |cb_expiry_evt |=> ((flags[CB_CELLS-1:0] & $past(cb_expiry_evt)) == $past(cb_expiry_evt)))
        else $error("balance expiry flag not latched");

    a_cb_needs_off: assert property (
        $rose(flags[0]) |-> $past(events.cb_timer_done[0] && events.cb_driver_off[0]))
        else $error("cell 1 flag set while driver still on");

    a_irq_follow: assert property (1'b1 |=> irq == $past(|(irq_st_r & irq_mask_r)))
        else $error("interrupt output does not follow status and mask");

    a_rdata_idle: assert property (!bus_req.rd |=> rd_data == RDATA_RST)
        else $error("read data not zero outside a read answer");

    // register port, interrupt bookkeeping, detail set priority and diagnostic cause
    a_rdata_flags: assert property (rd_fault |=> rd_data == $past(flags))
        else $error("flag read returned a wrong word");

    a_rdata_detail: assert property (rd_detail |=>
        rd_data == {{(DATA_W-OVF_DETAIL_W){1'b0}}, $past(details)})
        else $error("detail read returned a wrong word");

    a_rdata_irq: assert property (rd_irq_st |=> rd_data[IRQ_W-1:0] == $past(irq_st_r))
        else $error("status read did not return the value before clearing");

    a_irq_st_clear: assert property (
        rd_irq_st && !(|irq_evt) |=> irq_st_r == IRQ_STATUS_RST)
        else $error("interrupt status not cleared by its read");

    a_irq_st_set: assert property (
        (|irq_evt) |=> ((irq_st_r & $past(irq_evt)) == $past(irq_evt)))
        else $error("interrupt status bit not set by its event");

    a_irq_st_keep: assert property (
        !rd_irq_st |=> (($past(irq_st_r) & ~irq_st_r) == IRQ_STATUS_RST))
        else $error("interrupt status bit dropped without a read");

    a_mask_write: assert property (
        wr_irq_mask |=> irq_mask_r == $past(bus_req.wdata[IRQ_W-1:0]))
        else $error("mask write not taken");

    a_mask_keep: assert property (!wr_irq_mask |=> $stable(irq_mask_r))
        else $error("mask changed without a write");

    a_irq_needs_mask: assert property (irq |-> $past(|irq_mask_r))
        else $error("interrupt raised with every source masked");

    a_det_set_wins: assert property (
        (|det_set) |=> ((details & $past(det_set)) == $past(det_set)))
        else $error("overflow indicator lost against a clearing write");

    a_diag_cause: assert property (
        $rose(flags[DIAG_BIT]) |-> $past(events.diag_timeout))
        else $error("bit 14 rose without a diagnostic timeout");

    // per cell, timer expiry alone must not set the flag
    for (gi = 0; gi < CB_CELLS; gi++) begin : g_cb_chk
        a_cell_gate: assert property (@(posedge core_clk) disable iff (!rstn)
            $rose(flags[CB_LSB + gi])
            |-> $past(events.cb_timer_done[gi] && events.cb_driver_off[gi]))
            else $error("balance expiry flag set while the driver was on");
    end

    // an indicator rises only from its own source
    for (gi = 0; gi < OVF_DETAIL_W; gi++) begin : g_det_chk
        a_det_cause: assert property (@(posedge core_clk) disable iff (!rstn)
            $rose(details[gi]) |-> $past(det_set[gi]))
            else $error("overflow indicator rose without its source");
    end

    c_ovf_then_clear: cover property (ovf_evt ##[1:8] (wr_fault && !bus_req.wdata[OVF_BIT]));
    c_set_vs_clear: cover property (wr_fault && any_set && (|(flag_set & ~bus_req.wdata)));
    c_irq_raised: cover property ($rose(irq));
    c_irq_read_clear: cover property (rd_irq_st && (|irq_st_r));
    c_det_set_vs_clear: cover property (det_clr && (|det_set));

endmodule

/* File: shared/f3s_pkg.sv */
package f3s_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CB_CELLS = 14;
    localparam int OVF_DETAIL_W = 4;
    localparam int IRQ_W = 3;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFF_FAULT3 = 8'h26;
    localparam logic [ADDR_W-1:0] OFF_OVF_DETAIL = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h41;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h42;

    // field positions of third_fault_flags
    localparam int OVF_BIT = 15;
    localparam int DIAG_BIT = 14;
    localparam int CB_LSB = 0;

    // field positions of the overflow detail register
    localparam int DET_POS_BIT = 0;
    localparam int DET_NEG_BIT = 1;
    localparam int DET_SAMP_BIT = 2;
    localparam int DET_TOT_BIT = 3;

    // field positions of interrupt status and mask
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_DIAG_BIT = 1;
    localparam int IRQ_CB_BIT = 2;

    // reset values
    localparam logic [DATA_W-1:0] FLAGS_RST = 16'h0000;
    localparam logic [OVF_DETAIL_W-1:0] DETAIL_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } f3s_req_t;

    typedef struct packed {
        logic positive_sum_overflow;
        logic negative_sum_overflow;
        logic sample_counter_overflow;
        logic accumulator_total_overflow;
        logic diag_timeout;
        logic [CB_CELLS-1:0] cb_timer_done;
        logic [CB_CELLS-1:0] cb_driver_off;
    } f3s_evt_t;

endpackage

/* File: rtl/f3s_flag_cell.sv */
`timescale 1ns/1ps
module f3s_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic set_in,
    input wire logic clr_in,
    output logic q
);

    logic q_r;
    logic q_nxt;

    // a set in the clearing cycle wins, so no event is lost
    always_comb begin
        q_nxt = q_r;
        if (clr_in) begin
            q_nxt = 1'b0;
        end
        if (set_in) begin
            q_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

/* File: tb/f3s_host.sv */
`timescale 1ns/1ps
module f3s_host
    import f3s_pkg::*;
(
    input wire logic core_clk,
    input wire logic [DATA_W-1:0] rd_data,
    output f3s_req_t req
);
    initial begin
        req = '0;
    end

    // a zero bit clears its flag
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        // released lines must not keep the old value
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
        #1;
        d = rd_data;
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import f3s_pkg::*;
    logic core_clk;
    logic rstn;
    f3s_req_t bus_req;
    f3s_evt_t events;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] flags;
    logic [OVF_DETAIL_W-1:0] det;
    logic irq;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] e;
    int errors;
    int check_count;

    f3s_host i_host(.core_clk(core_clk), .rd_data(rd_data), .req(bus_req));
    f3s_top i_dut(.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .events(events),
        .rd_data(rd_data), .third_fault_flags(flags), .overflow_details(det), .irq(irq));

    task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic test_done;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one-cycle event burst, returns once it has been taken
    task automatic pulse(input logic [32:0] p);
        @(posedge core_clk);
        events <= p;
        @(posedge core_clk);
        events <= '0;
        #1;
    endtask

    task automatic t_reset;
        chk(FLAGS_RST, flags);
        i_host.rd(OFF_FAULT3, v);
        chk(FLAGS_RST, v);
        i_host.rd(OFF_OVF_DETAIL, v);
        chk(16'h0000, v);
        i_host.rd(8'h55, v);
        chk(16'h0000, v);
    endtask

    // sources in struct order: pos, neg, sample, total
    task automatic t_ovf;
        for (int i = 0; i < 4; i++) begin
            pulse(33'h1 << (32 - i));
            chk(16'h8000, flags);
            chk({12'h000, 4'h1 << i}, {12'h000, det});
            i_host.rd(OFF_FAULT3, v);
            chk(16'h8000, v);
            i_host.rd(OFF_OVF_DETAIL, v);
            chk({12'h000, 4'h1 << i}, v);
            i_host.wr(OFF_FAULT3, 16'hffff);
            chk(16'h8000, flags);
            i_host.wr(OFF_FAULT3, 16'h7fff);
            chk(16'h0000, flags);
            chk(16'h0000, {12'h000, det});
        end
        chk(16'h0000, {15'h0000, irq});
    endtask

    task automatic t_cells;
        pulse(33'h1 << 28);
        e = 16'h4000;
        chk(e, flags);
        for (int i = 0; i < CB_CELLS; i++) begin
            // timer alone is not enough, driver must also be off
            pulse(33'h1 << (14 + i));
            chk(e, flags);
            pulse((33'h1 << (14 + i)) | (33'h1 << i));
            e = e | (16'h0001 << i);
            chk(e, flags);
        end
        i_host.wr(OFF_FAULT3, 16'hffff);
        chk(16'h7fff, flags);
        i_host.wr(OFF_FAULT3, 16'h5555);
        chk(16'h5555, flags);
        i_host.wr(OFF_FAULT3, 16'h0000);
        chk(16'h0000, flags);
        // a clearing write in the cycle of an event loses
        fork
            pulse((33'h1 << 32) | (33'h1 << 28));
            i_host.wr(OFF_FAULT3, 16'h0000);
        join
        chk(16'hc000, flags);
        chk(16'h0001, {12'h000, det});
        i_host.wr(OFF_FAULT3, 16'h0000);
        chk(16'h0000, flags);
        chk(16'h0000, {12'h000, det});
    endtask

    task automatic t_irq;
        i_host.rd(OFF_IRQ_STATUS, v);
        chk(16'h0007, v);
        i_host.rd(OFF_IRQ_STATUS, v);
        chk(16'h0000, v);
        i_host.wr(OFF_IRQ_MASK, 16'h0002);
        i_host.rd(OFF_IRQ_MASK, v);
        chk(16'h0002, v);
        pulse(33'h1 << 32);
        @(posedge core_clk);
        #1;
        chk(16'h0000, {15'h0000, irq});
        pulse(33'h1 << 28);
        @(posedge core_clk);
        #1;
        chk(16'h0001, {15'h0000, irq});
        i_host.rd(OFF_IRQ_STATUS, v);
        chk(16'h0003, v);
        @(posedge core_clk);
        #1;
        chk(16'h0000, {15'h0000, irq});
    endtask

    // a reset in mid-run drops every latched bit
    task automatic t_rst_mid;
        pulse((33'h1 << 32) | (33'h1 << 28));
        chk(16'hc000, flags);
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(FLAGS_RST, flags);
        chk(16'h0000, {12'h000, det});
        chk(16'h0000, {15'h0000, irq});
        @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        i_host.rd(OFF_FAULT3, v);
        chk(FLAGS_RST, v);
        i_host.rd(OFF_IRQ_MASK, v);
        chk(16'h0000, v);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #2000000;
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        check_count = 0;
        rstn = 1'b0;
        events = '0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_ovf();
        t_cells();
        t_irq();
        t_rst_mid();
        test_done();
    end
endmodule
